// File: bench/cpu_bus_model.sv
// Purpose: CPU bus master stand-in that drives decoder requests.
// Assumes: Caller invokes put just after a falling clock edge.
// Notes:   Idle cycles invert the previous lines, so a second idle in a row shows the old address again.
`timescale 1ns/1ns
module cpu_bus_model
   import addr_decode_pkg::*;
(
   // Request toward the decoder
   output addr_decode_pkg::bus_req_t cpu_req
);
   bus_req_t req_reg;  // Request held for one cycle

   assign cpu_req = req_reg;

   initial req_reg = '0;

   // Issue one request, or release the lines
   task automatic put(input logic v, input logic w, input logic [23:0] a);
      if (v) begin
         req_reg = {v, w, a};
      end else begin
         req_reg = {1'b0, ~req_reg.write, ~req_reg.addr};
      end
   endtask
endmodule

// File: bench/mode_address_decoder_bench.sv
// Purpose: Self-checking bench for the mode address decoder.
// Assumes: Three variants, 32, 64 and 128-kbyte ROM, share all inputs.
// Notes:   Every select after reset is compared with a behavioural decode; ready flags with fixed values.
`timescale 1ns/1ns
module mode_address_decoder_bench;
   import addr_decode_pkg::*;
   logic        ref_clk   = 1'b0;  // System clock
   logic        rst_n     = 1'b0;  // Reset, active low
   logic [1:0]  mode_pins = 2'h1;  // Strap pins
   logic        ext_en    = 1'b0;  // Expansion enable
   logic        ram_en    = 1'b0;  // RAM enable
   bus_req_t    cpu_req;           // Request from the master model
   bus_sel_t    sel32, sel64;      // Decoded outputs of the small variants
   bus_sel_t    sel128;            // Decoded output of the largest variant
   logic        rdy32, rdy64;      // Mode ready flags
   logic        rdy128;            // Mode ready flag of the largest variant
   int          num_errors, checks_done, cycles, cur_mode;
   logic        pv, pw;            // Previous request
   logic [23:0] pa;
   logic [15:0] offs [18] = '{16'h0000, 16'h7fff, 16'h8000, 16'hdfff, 16'he000, 16'he07f,
      16'he080, 16'he87f, 16'he880, 16'hefff, 16'hf000, 16'hfe4f, 16'hfe50, 16'hfeff,
      16'hff00, 16'hff7f, 16'hff80, 16'hffff};
   logic [7:0]  pages [3] = '{8'h00, 8'h01, 8'hff};

   cpu_bus_model cpu_bus_model_inst (.cpu_req(cpu_req));
   mode_address_decoder #(.ROM_SIZE(ROM_32K)) mode_address_decoder_inst (.ref_clk(ref_clk),
      .rst_n(rst_n), .mode_pins(mode_pins), .external_expansion_enable(ext_en),
      .onchip_ram_enable(ram_en), .cpu_req(cpu_req), .mem_sel(sel32), .mode_ready(rdy32));
   mode_address_decoder #(.ROM_SIZE(ROM_64K)) mode_address_decoder_inst_big (.ref_clk(ref_clk),
      .rst_n(rst_n), .mode_pins(mode_pins), .external_expansion_enable(ext_en),
      .onchip_ram_enable(ram_en), .cpu_req(cpu_req), .mem_sel(sel64), .mode_ready(rdy64));
   mode_address_decoder #(.ROM_SIZE(ROM_128K)) mode_address_decoder_inst_max (.ref_clk(ref_clk),
      .rst_n(rst_n), .mode_pins(mode_pins), .external_expansion_enable(ext_en),
      .onchip_ram_enable(ram_en), .cpu_req(cpu_req), .mem_sel(sel128), .mode_ready(rdy128));

   // Clock generator
   always #10 ref_clk = ~ref_clk;

   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end

   // Behavioural decode of one request
   function automatic bus_sel_t ref_decode(int md, bit ex, bit ram, int kb, logic v,
                                           logic w, logic [23:0] a);
      int lo;
      int top;
      bit expd;
      bus_sel_t r;
      lo = a[15:0];
      expd = (md == 1) || ex;
      r = '0;
      if (!v) return r;
      // Illegal strap maps nothing
      if (md == 0) r.sel.reserved = 1'b1;
      else if (((md != 2) || (a[23:16] == 8'hff)) && lo >= 'he000) begin
         if (lo >= 'hff80) r.sel.io1 = 1'b1;
         else if (lo >= 'hfe50 && lo <= 'hfeff) r.sel.io2 = 1'b1;
         else if ((lo >= 'he880 && lo <= 'hefff) || lo >= 'hff00) begin
            r.sel.ext = expd && !ram;
            r.sel.ram = !r.sel.ext;
         end else if (lo >= 'he080 && lo <= 'he87f) begin
            r.sel.ext = expd && !ram;
            r.sel.reserved = !r.sel.ext;
         end else begin
            r.sel.ext = expd;
            r.sel.reserved = !expd;
         end
      end else if (md == 1) begin
         r.sel.ext = 1'b1;
      end else begin
         if (md == 3) top = (kb > 32) ? 'hdfff : 'h7fff;
         else top = (kb == 128) ? 'h1ffff : ((kb == 64) ? 'hffff : 'h7fff);
         if (((md == 3) ? lo : int'(a)) <= top) r.sel.rom = 1'b1;
         else if (md == 3) r.sel.reserved = 1'b1;
         else begin
            r.sel.ext = expd;
            r.sel.reserved = !expd;
         end
      end
      r.valid = 1'b1;
      r.write = w;
      r.addr = (md == 2) ? a : {8'h00, a[15:0]};
      return r;
   endfunction

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One bus cycle: judge the previous request, then issue the next
   task automatic step(input logic v, input logic w, input logic [23:0] a);
      @(negedge ref_clk);
      check(sel32, ref_decode(cur_mode, ext_en, ram_en, 32, pv, pw, pa));
      check(sel64, ref_decode(cur_mode, ext_en, ram_en, 64, pv, pw, pa));
      check(sel128, ref_decode(cur_mode, ext_en, ram_en, 128, pv, pw, pa));
      cpu_bus_model_inst.put(v, w, a);
      pv = v;
      pw = w;
      pa = a;
   endtask

   // Reset into a mode, check quiet outputs and strap timing
   task automatic start(input int md, input bit ex, input bit ram);
      @(negedge ref_clk);
      rst_n = 1'b0;
      mode_pins = md[1:0];
      ext_en = ex;
      ram_en = ram;
      cur_mode = md;
      pv = 1'b0;
      cpu_bus_model_inst.put(1'b0, 1'b0, 24'h000000);
      repeat (5) @(negedge ref_clk);
      check(sel32, 32'h0);
      check(sel64, 32'h0);
      check(sel128, 32'h0);
      check({29'h0, rdy32, rdy64, rdy128}, 32'h0);
      rst_n = 1'b1;
      repeat (2) begin
         @(negedge ref_clk);
         check({29'h0, rdy32, rdy64, rdy128}, 32'h0);
      end
      @(negedge ref_clk);
      check({29'h0, rdy32, rdy64, rdy128}, 32'h7);
   endtask

   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Main sequence: every mode, expansion and RAM setting
   initial begin
      void'($urandom(85));
      for (int md = 1; md <= 3; md++) begin
         for (int cfg = 0; cfg < 4; cfg++) begin
            start(md, cfg[0], cfg[1]);
            foreach (pages[p]) begin
               foreach (offs[i]) begin
                  step(1'b1, 1'($urandom), {pages[p], offs[i]});
               end
            end
            repeat (40) begin
               step(($urandom % 4) != 0, 1'($urandom), 24'($urandom));
            end
            step(1'b0, 1'b0, 24'h000000);
            step(1'b0, 1'b0, 24'h000000);
            $display("test mode %0d setting %0d done", md, cfg);
         end
      end
      // Illegal strap code: every access must come back reserved
      start(0, 1'b1, 1'b0);
      repeat (20) begin
         step(1'b1, 1'($urandom), 24'($urandom));
      end
      step(1'b0, 1'b0, 24'h000000);
      $display("test illegal strap done");
      test_done();
   end
endmodule

// File: bench/mode_address_decoder_sva.sv
// Purpose: Port-level checks of the mode address decoder.
// Assumes: Strap pins only change while reset is held.
// Notes:   Selects answer one cycle after the request.
`timescale 1ns/1ns
module decoder_checker
   import addr_decode_pkg::*;
#(
   parameter addr_decode_pkg::rom_size_t ROM_SIZE = addr_decode_pkg::ROM_32K
) (
   // Clock, reset and inputs
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire logic [1:0]           mode_pins,
   input wire logic                 external_expansion_enable,
   input wire logic                 onchip_ram_enable,
   input addr_decode_pkg::bus_req_t cpu_req,
   // Outputs watched
   input addr_decode_pkg::bus_sel_t mem_sel,
   input wire logic                 mode_ready
);
   logic [15:0] lo;     // Low address offset
   logic        upper;  // Mode reaches the upper region: modes 1 and 3, or page FF in mode 2
   logic        req;    // Useful request
   logic        expd;   // Expanded operation

   assign lo    = cpu_req.addr[15:0];
   // Illegal strap code maps nothing, so it has no upper region either
   assign upper = (mode_pins == 2'h1) || (mode_pins == 2'h3) ||
                  ((mode_pins == 2'h2) && (cpu_req.addr[23:16] == 8'hff));
   assign req   = cpu_req.valid && mode_ready;
   assign expd  = (mode_pins == 2'h1) || external_expansion_enable;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_norm_addr_trim: assert property (req && mode_pins != 2'h2 |=>
      mem_sel.addr == {8'h00, $past(lo)}) else $error("normal mode address not trimmed");
   a_adv_addr_full: assert property (req && mode_pins == 2'h2 |=>
      mem_sel.addr == $past(cpu_req.addr)) else $error("advanced mode address altered");
   a_rom56_limit: assert property (req && mode_pins == 2'h3 && ROM_SIZE != ROM_32K
      && lo < 16'he000 |=> mem_sel.sel.rom) else $error("large ROM window wrong");
   a_mode1_low_ext: assert property (req && mode_pins == 2'h1 && lo < 16'he000
      |=> mem_sel.sel.ext) else $error("mode 1 low region not external");
   a_rom32_gap: assert property (req && mode_pins == 2'h3 && ROM_SIZE == ROM_32K
      && lo < 16'he000 |=> mem_sel.sel.rom == !$past(cpu_req.addr[15])
      && mem_sel.sel.reserved == $past(cpu_req.addr[15])) else $error("small ROM gap wrong");
   a_io2_select: assert property (req && upper && lo >= 16'hfe50 && lo <= 16'hfeff
      |=> mem_sel.sel.io2) else $error("second bank not selected");
   a_io1_select: assert property (req && upper && lo >= 16'hff80
      |=> mem_sel.sel.io1) else $error("first bank not selected");
   a_ram_off_ext: assert property (req && upper && expd && !onchip_ram_enable &&
      ((lo >= 16'he880 && lo <= 16'hefff) || (lo >= 16'hff00 && lo <= 16'hff7f))
      |=> mem_sel.sel.ext) else $error("disabled RAM not external");
   a_single_chip: assert property (req && mode_pins != 2'h1 && !external_expansion_enable
      |=> !mem_sel.sel.ext) else $error("external select while single-chip");
   a_strap_ready: assert property ($rose(rst_n) |-> !mode_ready [*3] ##1 mode_ready)
      else $error("mode ready timing wrong");
   a_sel_onehot: assert property (mem_sel.valid |-> $onehot(mem_sel.sel))
      else $error("selects not one-hot");

   c_reserved: cover property (mem_sel.sel.reserved);
   c_external: cover property (mem_sel.sel.ext && mode_pins == 2'h2);
   c_rom: cover property (mem_sel.sel.rom && mode_pins == 2'h3);
endmodule

bind mode_address_decoder decoder_checker #(.ROM_SIZE(ROM_SIZE)) decoder_checker_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .mode_pins(mode_pins),
   .external_expansion_enable(external_expansion_enable),
   .onchip_ram_enable(onchip_ram_enable), .cpu_req(cpu_req),
   .mem_sel(mem_sel), .mode_ready(mode_ready));

// File: verilog/addr_decode_pkg.sv
// Purpose: Types shared by the mode address decoder files.
// Assumes: Constants come from the regs header.
// Notes:   Carriers are packed structs.
package addr_decode_pkg;
`include "addr_decode_regs.svh"

   // On-chip ROM capacity of the product variant
   typedef enum logic [1:0] {
      ROM_32K,
      ROM_64K,
      ROM_128K
   } rom_size_t;

   // Operating mode as taken from the strap pins
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_1,
      MODE_2,
      MODE_3
   } mode_t;

   // Access request from the CPU bus master
   typedef struct packed {
      logic                     valid;   // Access present this cycle
      logic                     write;   // Write when high
      logic [`ADEC_ADDR_W-1:0]  addr;    // Byte address
   } bus_req_t;

   // One-hot region selects
   typedef struct packed {
      logic rom;       // On-chip ROM
      logic ram;       // On-chip RAM
      logic io1;       // First register bank
      logic io2;       // Second register bank
      logic ext;       // External address space
      logic reserved;  // Reserved area, nothing selected
   } region_sel_t;

   // Decoded access toward memories and peripherals
   typedef struct packed {
      logic                     valid;   // Decoded access present
      logic                     write;   // Write when high
      logic [`ADEC_ADDR_W-1:0]  addr;    // Address as decoded for the mode
      region_sel_t              sel;     // Region selects
   } bus_sel_t;

endpackage

// File: verilog/addr_decode_regs.svh
// Purpose: Address boundaries, widths and timing counts for the mode address decoder.
// Assumes: Included by its bare name from the package and the decoder module.
// Notes:   Normal modes use 16-bit boundaries; advanced mode adds an 8-bit page.
`ifndef ADDR_DECODE_REGS_SVH
`define ADDR_DECODE_REGS_SVH

// Address widths
`define ADEC_ADDR_W        24             // Advanced mode space, 16 Mbytes
`define ADEC_NORM_W        16             // Normal mode space, 64 kbytes
`define ADEC_PAGE_W        8              // Upper address bits in advanced mode

// Boundaries in the low 16 bits
`define ADEC_ROM32_TOP     16'h7fff       // Top of a 32-kbyte ROM
`define ADEC_ROM56_TOP     16'hdfff       // Top of the usable 56 kbytes in mode 3
`define ADEC_UPPER_LO      16'he000       // Start of the on-chip upper region
`define ADEC_EXTWIN_LO     16'he000       // External window, first part
`define ADEC_EXTWIN_HI     16'he07f
`define ADEC_RSVWIN_LO     16'he080       // Reserved window below RAM
`define ADEC_RSVWIN_HI     16'he87f
`define ADEC_RAM_LO        16'he880       // Main on-chip RAM
`define ADEC_RAM_HI        16'hefff
`define ADEC_EXT2_LO       16'hf000       // External window, second part
`define ADEC_EXT2_HI       16'hfe4f
`define ADEC_IO2_LO        16'hfe50       // Second register bank
`define ADEC_IO2_HI        16'hfeff
`define ADEC_RAM2_LO       16'hff00       // 128-byte RAM window
`define ADEC_RAM2_HI       16'hff7f
`define ADEC_IO1_LO        16'hff80       // First register bank
`define ADEC_IO1_HI        16'hffff

// Advanced mode page and ROM tops
`define ADEC_TOP_PAGE      8'hff          // Page holding the on-chip upper region
`define ADEC_ADV_ROM32_TOP 24'h007fff
`define ADEC_ADV_ROM64_TOP 24'h00ffff
`define ADEC_ADV_ROM128_TOP 24'h01ffff

// Mode pin codes
`define ADEC_PINS_MODE1    2'h1
`define ADEC_PINS_MODE2    2'h2
`define ADEC_PINS_MODE3    2'h3

// Timing: edges of synchroniser delay before the mode strap is taken
`define ADEC_STRAP_WAIT    2'h2

`endif

// File: verilog/mode_address_decoder.sv
// Purpose: Classify each CPU bus address by operating mode into ROM, RAM, register
//          banks, external space or reserved area, and drive registered selects.
// Assumes: Mode pins are asynchronous straps; enable inputs come from ref_clk logic.
// Notes:   One cycle of latency from request to selects.
//
// Summary of operation
// - Modes 1 and 3 decode sixteen address bits
// - Mode 2 decodes the full 16-Mbyte space
// - Mode 3 large-ROM parts use only 56 kbytes
// - Mode 1 sends the low region external
// - Mode 3 small ROM: ROM, reserved gap, upper region
// - FE50 to FEFF selects second register bank
// - FF80 to FFFF selects first register bank
// - Modes 2 and 3 start single-chip, expansion enables
`timescale 1ns/1ns
`include "addr_decode_regs.svh"
module mode_address_decoder #(
   parameter addr_decode_pkg::rom_size_t ROM_SIZE = addr_decode_pkg::ROM_32K  // Variant
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Mode strap pins
   input  wire logic [1:0]           mode_pins,
   // Mode control bits from the system logic
   input  wire logic                 external_expansion_enable,
   input  wire logic                 onchip_ram_enable,
   // CPU bus request
   input  addr_decode_pkg::bus_req_t cpu_req,
   // Decoded access and mode status
   output addr_decode_pkg::bus_sel_t mem_sel,
   output logic                      mode_ready
);
   import addr_decode_pkg::*;

   // Inclusive range test on a 16-bit offset
   function automatic logic in_range(input logic [`ADEC_NORM_W-1:0] a,
                                     input logic [`ADEC_NORM_W-1:0] lo,
                                     input logic [`ADEC_NORM_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Map strap pins to a mode
   function automatic mode_t decode_mode(input logic [1:0] pins);
      mode_t m;
      m = MODE_NONE;
      unique case (pins)
         `ADEC_PINS_MODE1: m = MODE_1;
         `ADEC_PINS_MODE2: m = MODE_2;
         `ADEC_PINS_MODE3: m = MODE_3;
         default:          m = MODE_NONE;
      endcase
      decode_mode = m;
   endfunction

   logic [1:0]              pins_sync;          // Synchronised strap level
   logic [1:0]              strap_cnt_reg;      // Edges waited since reset release
   logic [1:0]              strap_cnt_next;
   mode_t                   mode_reg;           // Mode taken from the strap
   logic                    mode_ready_reg;     // Strap has been taken
   bus_sel_t                sel_reg;            // Registered decode result
   bus_sel_t                sel_next;

   // Decode helpers
   logic [`ADEC_NORM_W-1:0] a16;                // Low 16 address bits
   logic [`ADEC_PAGE_W-1:0] page;               // Upper 8 address bits
   logic                    advanced;           // Mode 2 in force
   logic                    expanded;           // External space reachable
   logic                    ram_to_ext;         // Starred regions go external
   logic                    upper;              // Access in the on-chip upper region
   logic                    rom_hit;            // Access inside usable ROM
   logic [`ADEC_NORM_W-1:0] norm_rom_top;       // ROM top in mode 3
   logic [`ADEC_ADDR_W-1:0] adv_rom_top;        // ROM top in mode 2
   region_sel_t             region;             // Selects before the valid gate

   // Strap pins cross into ref_clk here
   pin_sync pin_sync_inst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (mode_pins),
      .pin_out (pins_sync)
   );

   // Count the synchroniser delay after reset release
   always_comb begin
      strap_cnt_next = strap_cnt_reg;
      if (strap_cnt_reg != `ADEC_STRAP_WAIT) begin
         strap_cnt_next = strap_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_reg <= 2'h0;
      end else begin
         strap_cnt_reg <= strap_cnt_next;
      end
   end

   // Take the mode once the synchronised pins are valid, then hold it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg       <= MODE_NONE;
         mode_ready_reg <= 1'b0;
      end else if (!mode_ready_reg && (strap_cnt_reg == `ADEC_STRAP_WAIT)) begin
         mode_reg       <= decode_mode(pins_sync);
         mode_ready_reg <= 1'b1;
      end
   end

   // Mode dependent qualifiers
   always_comb begin
      a16      = cpu_req.addr[`ADEC_NORM_W-1:0];
      page     = cpu_req.addr[`ADEC_ADDR_W-1:`ADEC_NORM_W];
      advanced = (mode_reg == MODE_2);
      // Mode 1 is always expanded; modes 2 and 3 wait for the enable bit
      expanded = (mode_reg == MODE_1) ||
                 (((mode_reg == MODE_2) || (mode_reg == MODE_3)) &&
                  external_expansion_enable);
      ram_to_ext = expanded && !onchip_ram_enable;
      // Normal modes ignore the page bits entirely
      upper = (a16 >= `ADEC_UPPER_LO) &&
              (!advanced || (page == `ADEC_TOP_PAGE));
   end

   // ROM tops per variant and mode
   always_comb begin
      norm_rom_top = `ADEC_ROM32_TOP;
      adv_rom_top  = `ADEC_ADV_ROM32_TOP;
      unique case (ROM_SIZE)
         ROM_32K: begin
            norm_rom_top = `ADEC_ROM32_TOP;
            adv_rom_top  = `ADEC_ADV_ROM32_TOP;
         end
         ROM_64K: begin
            norm_rom_top = `ADEC_ROM56_TOP;
            adv_rom_top  = `ADEC_ADV_ROM64_TOP;
         end
         ROM_128K: begin
            norm_rom_top = `ADEC_ROM56_TOP;
            adv_rom_top  = `ADEC_ADV_ROM128_TOP;
         end
         default: begin
            // Two-bit type leaves one code unused
            norm_rom_top = `ADEC_ROM32_TOP;
            adv_rom_top  = `ADEC_ADV_ROM32_TOP;
         end
      endcase
   end

   // ROM hit; mode 1 has ROM disabled
   always_comb begin
      rom_hit = 1'b0;
      unique case (mode_reg)
         MODE_NONE: rom_hit = 1'b0;
         MODE_1:    rom_hit = 1'b0;
         MODE_2:    rom_hit = (cpu_req.addr <= adv_rom_top);
         MODE_3:    rom_hit = (a16 <= norm_rom_top);
      endcase
   end

   // Region classification
   always_comb begin
      region = '0;
      if (mode_reg == MODE_NONE) begin
         // Unknown strap or not yet taken: nothing is mapped
         region = '0;
      end else if (upper) begin
         if (in_range(a16, `ADEC_IO1_LO, `ADEC_IO1_HI)) begin
            region.io1 = 1'b1;
         end else if (in_range(a16, `ADEC_IO2_LO, `ADEC_IO2_HI)) begin
            region.io2 = 1'b1;
         end else if (in_range(a16, `ADEC_RAM_LO, `ADEC_RAM_HI) ||
                      in_range(a16, `ADEC_RAM2_LO, `ADEC_RAM2_HI)) begin
            // RAM, or external once RAM is disabled in an expanded mode
            region.ram = !ram_to_ext;
            region.ext = ram_to_ext;
         end else if (in_range(a16, `ADEC_RSVWIN_LO, `ADEC_RSVWIN_HI)) begin
            // Reserved window below RAM also opens when RAM is disabled in an expanded mode
            region.ext = ram_to_ext;
         end else if (in_range(a16, `ADEC_EXTWIN_LO, `ADEC_EXTWIN_HI) ||
                      in_range(a16, `ADEC_EXT2_LO, `ADEC_EXT2_HI)) begin
            // External windows exist only while expanded
            region.ext = expanded;
         end
      end else if (rom_hit) begin
         region.rom = 1'b1;
      end else if (mode_reg == MODE_3) begin
         // Between the ROM top and E000 in mode 3 lies a reserved gap
         region = '0;
      end else begin
         // Low region outside ROM: mode 1 and expanded mode 2
         region.ext = expanded;
      end
      // Nothing selected means a reserved area
      region.reserved = !(region.rom || region.ram || region.io1 ||
                          region.io2 || region.ext);
   end

   // Gate by request valid and form the outgoing address
   always_comb begin
      sel_next       = '0;
      sel_next.valid = cpu_req.valid;
      sel_next.write = cpu_req.valid && cpu_req.write;
      if (cpu_req.valid) begin
         sel_next.sel = region;
         // Normal modes present only sixteen bits
         if (advanced) begin
            sel_next.addr = cpu_req.addr;
         end else begin
            sel_next.addr = {{`ADEC_PAGE_W{1'b0}}, a16};
         end
      end
   end

   // Registered decode result
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg <= '0;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // Outputs straight from flip-flops
   assign mem_sel    = sel_reg;
   assign mode_ready = mode_ready_reg;

endmodule

// File: verilog/pin_sync.sv
// Purpose: Two-flop synchroniser for the 2-bit mode strap pins.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ns
module pin_sync (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Pins in, synchronised level out
   input  wire logic [1:0] pin_in,
   output logic      [1:0] pin_out
);

   logic [1:0] stage1_reg;   // First stage, read only by the second
   logic [1:0] stage2_reg;   // Second stage

   // Two stages in series
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= 2'h0;
         stage2_reg <= 2'h0;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign pin_out = stage2_reg;

endmodule
